// ==== verilog/tzo_consts.svh ====
// Purpose: constants for the timer zero option control block
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits
// Notes: printed register index times four gives the byte address
`ifndef TZO_CONSTS_SVH
`define TZO_CONSTS_SVH
`define TZO_IDX_INTCTL 12'h18b
`define TZO_IDX_OPTION 12'h181
`define TZO_ADDR_INTCTL 12'h62c
`define TZO_ADDR_OPTION 12'h604
`define TZO_ADDR_PULLEN 12'h700
`define TZO_ADDR_IRQ_STAT 12'h704
`define TZO_ADDR_IRQ_CLR 12'h708
`define TZO_ADDR_IRQ_EN 12'h70c
`define TZO_ADDR_COUNT 12'h710
`define TZO_ADDR_WDOG 12'h714
`define TZO_OPTION_RST 8'hff
`define TZO_INTCTL_RST 8'h00
`define TZO_PULLEN_RST 8'h00
`define TZO_BIT_PU_DIS 7
`define TZO_BIT_EDGE 6
`define TZO_BIT_SRC 5
`define TZO_BIT_T0EDGE 4
`define TZO_BIT_PSA 3
`define TZO_BIT_EXT_IRQ_FLAG 1
`define TZO_BIT_CHANGE_IRQ_FLAG 0
`define TZO_EV_OVF 0
`define TZO_EV_EXT 1
`define TZO_EV_WDT 2
`define TZO_EV_IOC 3
`endif

// ==== verilog/tzo_pkg.sv ====
// Purpose: types for the timer zero option control block
// Assumes: nothing beyond the constants header
// Notes: prescaler selection encoding
package tzo_pkg;
	typedef enum logic {
		TZO_PS_TIMER,
		TZO_PS_WDOG
	} tzo_psa_type;
endpackage

// ==== verilog/tzo_option_ctrl.sv ====
// Purpose: timer zero and watchdog option control with APB registers
// Assumes: pins synchronous to pclk; pclk is the instruction-cycle clock
// Notes: events set sticky status bits gated by an enable register
`timescale 1ns/10ps
`include "tzo_consts.svh"

module tzo_option_ctrl
	import tzo_pkg::*;
(
	input wire logic pclk, // Instruction clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic timer_zero_ext_clock_pin, // External timer clock
	input wire logic ext_irq_pin, // External interrupt pin
	input wire logic change_mismatch, // Pin change mismatch level
	output logic [7:0] pullup_active, // Per-pin weak pull-up on
	output logic watchdog_tick, // Watchdog advance pulse
	output logic irq // Level interrupt
);
	logic [7:0] option_q;
	logic [7:0] intctl_q;
	logic [7:0] per_pin_pullup_enable_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_en_q;
	logic [7:0] timer_zero_count_q;
	logic [7:0] presc_q;
	logic [7:0] wdog_q;
	logic t0pin_q, extpin_q;
	logic wr, rd, addr_ok;
	logic t0_edge, ext_edge, src_ev, presc_out, timer_inc, wdog_inc, ovf;
	logic ext_irq_edge_select, timer_zero_source_select, timer_zero_edge_select, port_pullup_disable;
	logic [2:0] prescaler_rate;
	tzo_psa_type prescaler_assign;
	logic [7:0] presc_d;

	// Edge detection on a pin: falling when sel is one, rising otherwise
	function automatic logic edge_seen(input logic prev, input logic now, input logic fall);
		edge_seen = fall ? (prev & ~now) : (~prev & now);
	endfunction

	// Mask for prescaler tap: ones below bit n
	function automatic logic [7:0] low_mask(input logic [3:0] n);
		low_mask = 8'(({8'h0, 8'hff} << n) >> 8);
	endfunction

	assign port_pullup_disable = option_q[`TZO_BIT_PU_DIS];
	assign ext_irq_edge_select = option_q[`TZO_BIT_EDGE];
	assign timer_zero_source_select = option_q[`TZO_BIT_SRC];
	assign timer_zero_edge_select = option_q[`TZO_BIT_T0EDGE];
	assign prescaler_assign = tzo_psa_type'(option_q[`TZO_BIT_PSA]);
	assign prescaler_rate = option_q[2:0];

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		unique case (paddr)
			`TZO_ADDR_OPTION, `TZO_ADDR_INTCTL, `TZO_ADDR_PULLEN, `TZO_ADDR_IRQ_STAT,
			`TZO_ADDR_IRQ_CLR, `TZO_ADDR_IRQ_EN, `TZO_ADDR_COUNT, `TZO_ADDR_WDOG: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	// Read data registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd & ~penable) begin
			unique case (paddr)
				`TZO_ADDR_OPTION: prdata <= {24'h0, option_q};
				`TZO_ADDR_INTCTL: prdata <= {24'h0, intctl_q};
				`TZO_ADDR_PULLEN: prdata <= {24'h0, per_pin_pullup_enable_q};
				`TZO_ADDR_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
				`TZO_ADDR_IRQ_EN: prdata <= {28'h0, irq_en_q};
				`TZO_ADDR_COUNT: prdata <= {24'h0, timer_zero_count_q};
				`TZO_ADDR_WDOG: prdata <= {24'h0, wdog_q};
				default: prdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_q <= `TZO_OPTION_RST;
			per_pin_pullup_enable_q <= `TZO_PULLEN_RST;
			irq_en_q <= 4'h0;
		end else if (wr) begin
			if (paddr == `TZO_ADDR_OPTION) begin
				option_q <= pwdata[7:0];
			end
			if (paddr == `TZO_ADDR_PULLEN) begin
				per_pin_pullup_enable_q <= pwdata[7:0];
			end
			if (paddr == `TZO_ADDR_IRQ_EN) begin
				irq_en_q <= pwdata[3:0];
			end
		end
	end

	assign pullup_active = port_pullup_disable ? 8'h00 : per_pin_pullup_enable_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0pin_q <= 1'b0;
			extpin_q <= 1'b0;
		end else begin
			t0pin_q <= timer_zero_ext_clock_pin;
			extpin_q <= ext_irq_pin;
		end
	end

	assign ext_edge = edge_seen(extpin_q, ext_irq_pin, ext_irq_edge_select);
	assign t0_edge = edge_seen(t0pin_q, timer_zero_ext_clock_pin, timer_zero_edge_select);
	assign src_ev = timer_zero_source_select ? t0_edge : 1'b1;

	// Shared prescaler source: timer event or watchdog clock tick
	always_comb begin
		presc_d = presc_q;
		presc_out = 1'b0;
		if (prescaler_assign == TZO_PS_WDOG || src_ev) begin
			presc_d = presc_q + 8'h01;
			presc_out = (presc_q & low_mask(prescaler_assign == TZO_PS_WDOG ? {1'b0, prescaler_rate}
				: {1'b0, prescaler_rate} + 4'h1)) == low_mask(prescaler_assign == TZO_PS_WDOG
				? {1'b0, prescaler_rate} : {1'b0, prescaler_rate} + 4'h1);
		end
	end

	assign timer_inc = (prescaler_assign == TZO_PS_TIMER) ? presc_out : src_ev;
	assign wdog_inc = (prescaler_assign == TZO_PS_WDOG) ? presc_out : 1'b1;
	assign ovf = timer_inc & (timer_zero_count_q == 8'hff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= 8'h00;
		end else if (wr && paddr == `TZO_ADDR_OPTION) begin
			presc_q <= 8'h00;
		end else begin
			presc_q <= presc_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_zero_count_q <= 8'h00;
		end else if (wr && paddr == `TZO_ADDR_COUNT) begin
			timer_zero_count_q <= pwdata[7:0];
		end else if (timer_inc) begin
			timer_zero_count_q <= timer_zero_count_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_q <= 8'h00;
			watchdog_tick <= 1'b0;
		end else begin
			watchdog_tick <= wdog_inc;
			if (wdog_inc) begin
				wdog_q <= wdog_q + 8'h01;
			end
		end
	end

	// Interrupt control; hardware set wins over software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intctl_q <= `TZO_INTCTL_RST;
		end else begin
			if (wr && paddr == `TZO_ADDR_INTCTL) begin
				intctl_q <= pwdata[7:0];
			end
			if (ext_edge) begin
				intctl_q[`TZO_BIT_EXT_IRQ_FLAG] <= 1'b1;
			end
			if (change_mismatch) begin
				intctl_q[`TZO_BIT_CHANGE_IRQ_FLAG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 4'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr && paddr == `TZO_ADDR_IRQ_CLR) ? pwdata[3:0] : 4'h0))
				| {change_mismatch, wdog_inc & (wdog_q == 8'hff), ext_edge, ovf};
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	property p_pullup;
		@(posedge pclk) disable iff (!presetn) option_q[7] |-> pullup_active == 8'h00;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up active while disabled");
	property p_pin_pu;
		@(posedge pclk) disable iff (!presetn) !option_q[7] |-> pullup_active == per_pin_pullup_enable_q;
	endproperty
	a_pin_pu: assert property (p_pin_pu) else $error("pin pull-up mismatch");
	property p_rise;
		@(posedge pclk) disable iff (!presetn)
		(!option_q[6] && !extpin_q && ext_irq_pin) |=> intctl_q[1];
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge not flagged");
	property p_fall;
		@(posedge pclk) disable iff (!presetn)
		(option_q[6] && extpin_q && !ext_irq_pin) |=> intctl_q[1];
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge not flagged");
	property p_internal;
		@(posedge pclk) disable iff (!presetn)
		(!option_q[5] && option_q[3] && !wr) |=> timer_zero_count_q == $past(timer_zero_count_q) + 8'h01;
	endproperty
	a_internal: assert property (p_internal) else $error("internal count missed");
	property p_ext_hold;
		@(posedge pclk) disable iff (!presetn)
		(option_q[5] && option_q[3] && !t0_edge && !wr) |=> $stable(timer_zero_count_q);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("count without pin edge");
	property p_wdog_direct;
		@(posedge pclk) disable iff (!presetn) !option_q[3] |=> watchdog_tick;
	endproperty
	a_wdog_direct: assert property (p_wdog_direct) else $error("watchdog not undivided");
	// Rate 1 on the watchdog: every window of four ticks holds two
	property p_div;
		@(posedge pclk) disable iff (!presetn)
		(option_q[3] && option_q[2:0] == 3'h1 && !wr) ##1
		(option_q[3] && option_q[2:0] == 3'h1 && !wr) [*4] |->
		$countones({watchdog_tick, $past(watchdog_tick), $past(watchdog_tick, 2), $past(watchdog_tick, 3)}) == 2;
	endproperty
	a_div: assert property (p_div) else $error("watchdog rate wrong");
	property p_change_irq_flag;
		@(posedge pclk) disable iff (!presetn) change_mismatch |=> intctl_q[0];
	endproperty
	a_change_irq_flag: assert property (p_change_irq_flag) else $error("change flag not set");

	// External source, falling edge selected
	property p_t0_fall;
		@(posedge pclk) disable iff (!presetn)
		(option_q[5] && option_q[3] && option_q[4] && t0pin_q && !timer_zero_ext_clock_pin && !wr) |=>
		timer_zero_count_q == $past(timer_zero_count_q) + 8'h01;
	endproperty
	a_t0_fall: assert property (p_t0_fall) else $error("falling pin edge not counted");

	// External source, rising edge selected
	property p_t0_rise;
		@(posedge pclk) disable iff (!presetn)
		(option_q[5] && option_q[3] && !option_q[4] && !t0pin_q && timer_zero_ext_clock_pin && !wr) |=>
		timer_zero_count_q == $past(timer_zero_count_q) + 8'h01;
	endproperty
	a_t0_rise: assert property (p_t0_rise) else $error("rising pin edge not counted");

	// No pin edge, no count, whoever holds the prescaler
	property p_src_hold;
		@(posedge pclk) disable iff (!presetn)
		(option_q[5] && !t0_edge && !wr) |=>
		$stable(timer_zero_count_q);
	endproperty
	a_src_hold: assert property (p_src_hold) else $error("count moved without source");

	// Timer at rate 0 advances once in two cycles
	property p_timer_div0;
		@(posedge pclk) disable iff (!presetn)
		(!option_q[5] && !option_q[3] && option_q[2:0] == 3'h0 && !wr) ##1
		(!option_q[5] && !option_q[3] && option_q[2:0] == 3'h0 && !wr) |=>
		timer_zero_count_q == $past(timer_zero_count_q, 2) + 8'h01;
	endproperty
	a_timer_div0: assert property (p_timer_div0) else $error("timer rate 1:2 wrong");

	// Rising edge selected: a falling pin leaves the flag alone
	property p_rise_none;
		@(posedge pclk) disable iff (!presetn)
		(!option_q[6] && extpin_q && !ext_irq_pin && !intctl_q[1] && !(wr && paddr == `TZO_ADDR_INTCTL)) |=>
		!intctl_q[1];
	endproperty
	a_rise_none: assert property (p_rise_none) else $error("wrong edge flagged");

	// Falling edge selected: a rising pin leaves the flag alone
	property p_fall_none;
		@(posedge pclk) disable iff (!presetn)
		(option_q[6] && !extpin_q && ext_irq_pin && !intctl_q[1] && !(wr && paddr == `TZO_ADDR_INTCTL)) |=>
		!intctl_q[1];
	endproperty
	a_fall_none: assert property (p_fall_none) else $error("wrong edge flagged");

	// Flag stays until software writes the register
	property p_ext_irq_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(intctl_q[1] && !(wr && paddr == `TZO_ADDR_INTCTL)) |=>
		intctl_q[1];
	endproperty
	a_ext_irq_flag_sticky: assert property (p_ext_irq_flag_sticky) else $error("edge flag lost");

	// Status bit sticky until cleared
	property p_stat_sticky;
		@(posedge pclk) disable iff (!presetn)
		(irq_stat_q[1] && !(wr && paddr == `TZO_ADDR_IRQ_CLR && pwdata[1])) |=>
		irq_stat_q[1];
	endproperty
	a_stat_sticky: assert property (p_stat_sticky) else $error("edge status lost");

	// Clear with no new edge empties the bit
	property p_stat_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `TZO_ADDR_IRQ_CLR && pwdata[1] && !ext_edge) |=>
		!irq_stat_q[1];
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("edge status not cleared");

	// Mismatch also raises its status bit
	property p_mism_stat;
		@(posedge pclk) disable iff (!presetn)
		change_mismatch |=>
		irq_stat_q[`TZO_EV_IOC];
	endproperty
	a_mism_stat: assert property (p_mism_stat) else $error("mismatch status not set");

	// Timer wrap raises its status bit
	property p_ovf_flag;
		@(posedge pclk) disable iff (!presetn)
		ovf |=>
		irq_stat_q[`TZO_EV_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow status not set");

	// Watchdog wrap raises its status bit
	property p_wdog_wrap;
		@(posedge pclk) disable iff (!presetn)
		(wdog_inc && wdog_q == 8'hff) |=>
		irq_stat_q[`TZO_EV_WDT];
	endproperty
	a_wdog_wrap: assert property (p_wdog_wrap) else $error("watchdog status not set");

	// Enabled status drives the level interrupt
	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		(irq_stat_q[1] && irq_en_q[1]) |->
		irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	c_ovf: cover property (@(posedge pclk) disable iff (!presetn) ovf);
	c_ext: cover property (@(posedge pclk) disable iff (!presetn) ext_edge);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	c_t0: cover property (@(posedge pclk) disable iff (!presetn) option_q[5] && t0_edge);
	c_clr: cover property (@(posedge pclk) disable iff (!presetn) wr && paddr == `TZO_ADDR_IRQ_CLR);
endmodule

// ==== sim/tzo_pin_model.sv ====
// Purpose: far-side pins, external timer clock and interrupt input
// Assumes: bench requests levels; pins move on pclk only
// Notes: pins stand still unless a new level is asked for
`timescale 1ns/10ps
module tzo_pin_model (
	input wire logic pclk, // Clock
	input wire logic clk_req, // Wanted timer clock level
	input wire logic irq_req, // Wanted interrupt level
	output logic clk_pin, // Timer clock pin
	output logic irq_pin // Interrupt pin
);
	always @(posedge pclk) begin
		clk_pin <= clk_req;
		irq_pin <= irq_req;
	end
endmodule

// ==== sim/timer0_wdt_option_control_tb.sv ====
// Purpose: self-checking bench for the timer zero option control
// Assumes: zero wait APB slave, count latched at setup edge
// Notes: 128-cycle windows make prescaled counts exact, except the timer at rate 7 (1:256), which is not checked
`timescale 1ns/10ps
`include "tzo_consts.svh"
module timer0_wdt_option_control_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic clk_req = 0, irq_req = 0, mism = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, tclk, ipin, wd_tick, irq, err;
	logic [7:0] pu, a, b, p, o;
	int errors = 0, samples_checked = 0;
	always #5 pclk = ~pclk;
	tzo_option_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_zero_ext_clock_pin(tclk), .ext_irq_pin(ipin),
		.change_mismatch(mism), .pullup_active(pu), .watchdog_tick(wd_tick), .irq(irq));
	tzo_pin_model u_pins (.pclk(pclk), .clk_req(clk_req), .irq_req(irq_req), .clk_pin(tclk),
		.irq_pin(ipin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count advance over 128 cycles between two setup edges
	task automatic measure(input logic [11:0] ad, output logic [7:0] dl);
		xfer(1'b0, ad, 32'h0);
		a = rd[7:0];
		repeat (125) @(posedge pclk);
		xfer(1'b0, ad, 32'h0);
		dl = rd[7:0] - a;
	endtask
	task automatic tick_step(input logic lvl, input logic [7:0] exp);
		xfer(1'b0, `TZO_ADDR_COUNT, 32'h0);
		a = rd[7:0];
		clk_req <= lvl;
		repeat (4) @(posedge pclk);
		xfer(1'b0, `TZO_ADDR_COUNT, 32'h0);
		check(8'(rd[7:0] - a), exp);
	endtask
	task automatic pin_edge(input logic lvl);
		irq_req <= lvl;
		repeat (4) @(posedge pclk);
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		void'($urandom(91));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `TZO_ADDR_OPTION, 32'h0);
		check(rd, 32'hff);
		check(pready, 1'b1);
		check(pu, 8'h00);
		for (int i = 0; i < 6; i++) begin
			p = $urandom;
			o = $urandom;
			o[7] = i[0];
			xfer(1'b1, `TZO_ADDR_PULLEN, {24'h0, p});
			xfer(1'b1, `TZO_ADDR_OPTION, {24'h0, o});
			xfer(1'b0, `TZO_ADDR_OPTION, 32'h0);
			check(rd, {24'h0, o});
			check(pu, o[7] ? 8'h00 : p);
		end
		for (int r = 0; r < 8; r++) begin
			xfer(1'b1, `TZO_ADDR_OPTION, 32'h08 | r);
			measure(`TZO_ADDR_WDOG, b);
			check(b, 128 >> r);
			measure(`TZO_ADDR_COUNT, b);
			check(b, 128);
			xfer(1'b1, `TZO_ADDR_OPTION, r);
			measure(`TZO_ADDR_WDOG, b);
			check(b, 128);
			check(wd_tick, 1'b1);
			measure(`TZO_ADDR_COUNT, b);
			if (r < 7)
				check(b, 128 >> (r + 1));
		end
		for (int e = 0; e < 2; e++) begin
			xfer(1'b1, `TZO_ADDR_OPTION, 32'h28 | (e << 4));
			clk_req <= e[0];
			repeat (4) @(posedge pclk);
			tick_step(!e[0], 8'h01);
			tick_step(e[0], 8'h00);
		end
		xfer(1'b1, `TZO_ADDR_IRQ_EN, 32'h2);
		for (int e = 0; e < 2; e++) begin
			xfer(1'b1, `TZO_ADDR_OPTION, 32'h08 | (e << 6));
			pin_edge(!e[0]);
			xfer(1'b1, `TZO_ADDR_INTCTL, 32'h0);
			xfer(1'b1, `TZO_ADDR_IRQ_CLR, 32'hf);
			pin_edge(e[0]);
			xfer(1'b0, `TZO_ADDR_INTCTL, 32'h0);
			check(rd[1], 1'b0);
			check(irq, 1'b0);
			pin_edge(!e[0]);
			xfer(1'b0, `TZO_ADDR_INTCTL, 32'h0);
			check(rd[1], 1'b1);
			check(irq, 1'b1);
			xfer(1'b1, `TZO_ADDR_IRQ_CLR, 32'h2);
			@(negedge pclk);
			check(irq, 1'b0);
		end
		xfer(1'b1, `TZO_ADDR_IRQ_EN, 32'h0);
		pin_edge(1'b1);
		pin_edge(1'b0);
		xfer(1'b0, `TZO_ADDR_IRQ_STAT, 32'h0);
		check(rd[1], 1'b1);
		check(irq, 1'b0);
		xfer(1'b0, 12'h7f0, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		mism <= 1'b1;
		rst();
		xfer(1'b0, `TZO_ADDR_INTCTL, 32'h0);
		check(rd[0], 1'b1);
		mism <= 1'b0;
		rst();
		xfer(1'b0, `TZO_ADDR_INTCTL, 32'h0);
		check(rd[0], 1'b0);
		report_and_stop();
	end
	initial begin
		#900000;
		errors++;
		report_and_stop();
	end
endmodule
